// >>> tcas_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcas_host_model
	import tcas_pkg::*;
(
	input wire logic clk_in,
	input wire logic rb_in,
	input wire logic rb_oe_n_in,
	input wire logic chain_out_in,
	output logic frame_out,
	output logic bck_out,
	output logic sdata_out,
	output logic chain_drv_out
);
	logic rb_cap [256];
	logic oe_cap [256];
	logic co_cap [256];

	// The link idles with its clock parked low and the frame pin low.
	initial begin
		frame_out = 1'h0;
		bck_out = 1'h0;
		sdata_out = 1'h0;
		chain_drv_out = 1'h1;
	end

	// One frame of n packets; the lead pulse length is a knob so a bad lead-in can be sent.
	// Chain output is captured halfway through the low phase, after its lag from the rise has passed.
	task automatic send(input logic [31:0] w [8], input int n, input int pulse, input int chain_at);
		for (int i = 0; i < n * PKT_BITS; i++) begin
			@(posedge clk_in);
			bck_out <= 1'h0;
			sdata_out <= w[i / 32][31 - i % 32];
			frame_out <= (i < pulse);
			// The devices ahead on the chain all take audio, so none is command-only.
			chain_drv_out <= (chain_at < 0) || (i >= chain_at);
			repeat (2) @(posedge clk_in);
			if (i > 0) co_cap[i - 1] = chain_out_in;
			repeat (2) @(posedge clk_in);
			bck_out <= 1'h1;
			repeat (2) @(posedge clk_in);
			oe_cap[i] = !rb_oe_n_in;
			rb_cap[i] = rb_oe_n_in ? !rb_in : rb_in;
			@(posedge clk_in); // Four clocks low and four high make the 160 ns bit period.
		end
		@(posedge clk_in);
		bck_out <= 1'h0;
		frame_out <= 1'h0;
		// A released data line must not look like the last bit sent.
		sdata_out <= !sdata_out;
		repeat (16) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// >>> tcas_pkg.sv
package tcas_pkg;

	// Command word layout, shared by the command and extended packets.
	localparam int PKT_BITS = 32;
	localparam int ID_ASSIGN_BIT = 31;
	localparam int EXT_BIT = 30;
	localparam int CHAIN_SEL_BIT = 29;
	localparam int DEV_ID_LSB = 24;
	localparam int RW_BIT = 23;
	localparam int REG_ID_LSB = 16;
	localparam int DATA_LSB = 8;
	localparam int SAMPLE_LSB = 8;

	// Device identity values on the chain.
	localparam logic [4:0] NO_ID = 5'h00;
	localparam logic [4:0] HEAD_ID = 5'h01;
	localparam logic [4:0] MAX_ID = 5'h1e;
	localparam logic [4:0] BROADCAST_ID = 5'h1f;

	// Device registers reached by frame commands.
	localparam logic [6:0] REG_AVAIL = 7'h13;
	localparam int AVAIL_BIT = 4;
	localparam logic [6:0] REG_DEVID = 7'h17;

	// Frame timing in bit-clock periods, and the number of qualifying frames.
	localparam logic [1:0] LEAD_PULSE_BITS = 2'h2;
	localparam logic [1:0] QUAL_FRAMES = 2'h2;
	localparam logic [4:0] RD_DECIDE_BIT = 5'h0e;
	localparam logic [4:0] RD_ADDR_BIT = 5'h0f;
	localparam logic [4:0] RD_LAST_BIT = 5'h17;
	localparam logic [4:0] PKT_LAST_BIT = 5'h1f;

	// Synchroniser lanes.
	localparam int SY_BCK = 0;
	localparam int SY_FRM = 1;
	localparam int SY_DIN = 2;
	localparam int SY_CHN = 3;

	// Bus register byte addresses and fields.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_AUDIO_L = 8'h08;
	localparam logic [7:0] A_AUDIO_R = 8'h0c;
	localparam logic [7:0] A_WR_COUNT = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_EXT, PH_AUDIO, PH_IDASSIGN} tcas_phase_t;

	typedef enum logic [1:0] {SL_NONE, SL_LEFT, SL_RIGHT} tcas_slot_t;

	typedef struct packed {
		logic [3:0] sync_m;
		logic [3:0] sync_s;
		logic bck_p;
		logic frm_prev;
		logic [1:0] hi_cnt;
		logic [1:0] qual;
		tcas_phase_t phase;
		logic [4:0] pkt_bit;
		logic [31:0] shift;
		tcas_slot_t slot;
		logic aud_done;
		logic [4:0] id_cnt;
		logic [4:0] dev_id;
		logic id_valid;
		logic avail;
		logic rd_active;
		logic [6:0] rd_addr;
		logic wr_en;
		logic [6:0] wr_addr;
		logic [7:0] wr_data;
		logic chain_out;
		logic rb_data;
		logic rb_oe_n;
		logic [23:0] audio_l;
		logic [23:0] audio_r;
		logic [15:0] wr_count;
		logic ctrl_en;
		logic aw_hold;
		logic w_hold;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tcas_state_t;

	localparam tcas_state_t TCAS_RST = '{phase: PH_IDLE, slot: SL_NONE, ctrl_en: 1'b1,
		rb_oe_n: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// >>> tcas_regmem.sv
`timescale 1ns/1ps
`default_nettype none
module tcas_regmem #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
) (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [DATA_W-1:0] rd_data_out
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_size
		$error("Register memory needs nonzero widths.");
	end

	// Registered read keeps the readback path off the memory decode.
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end

endmodule
`default_nettype wire

// >>> tcas_slave.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcas_slave
	import tcas_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic FRAME_START_PIN_IN,
	input wire logic BIT_CLOCK_PIN_IN,
	input wire logic SERIAL_IN_PIN_IN,
	input wire logic CHAIN_IN_PIN_IN,
	output logic READBACK_PIN_OUT,
	output logic READBACK_PIN_OE_N_OUT,
	output logic CHAIN_OUT_PIN_OUT,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN
);

	tcas_state_t s;
	tcas_state_t n;
	logic [7:0] mem_q;
	logic [7:0] rd_byte;
	logic [31:0] word;
	logic bck_rise;
	logic bck_fall;
	logic frm;
	logic din;
	logic chin;

	// Matches a header against this device; bits below the direction bit may be absent.
	function automatic logic tcas_match(input logic [31:0] w, input logic [4:0] id,
		input logic idv);
		logic [4:0] dst;
		dst = w[DEV_ID_LSB +: 5];
		tcas_match = !w[CHAIN_SEL_BIT] &&
			((idv && dst == id && dst != NO_ID) || (dst == BROADCAST_ID && !w[RW_BIT]));
	endfunction

	tcas_regmem #(
		.ADDR_W(7),
		.DATA_W(8)
	) u_regs (
		.clk_in(CLK_SYS_IN),
		.wr_en_in(s.wr_en),
		.wr_addr_in(s.wr_addr),
		.wr_data_in(s.wr_data),
		.rd_addr_in(s.rd_addr),
		.rd_data_out(mem_q)
	);

	// Edges are found on the second synchroniser stage only.
	assign bck_rise = s.sync_s[SY_BCK] && !s.bck_p;
	assign bck_fall = !s.sync_s[SY_BCK] && s.bck_p;
	assign frm = s.sync_s[SY_FRM];
	assign din = s.sync_s[SY_DIN];
	assign chin = s.sync_s[SY_CHN];
	assign word = {s.shift[30:0], din};
	assign rd_byte = (s.rd_addr == REG_DEVID) ? {3'h0, s.dev_id} : mem_q;

	// All next-state logic: link sampling, frame decode and the bus slave.
	always_comb begin
		n = s;
		n.wr_en = 1'b0;
		n.sync_m = {CHAIN_IN_PIN_IN, SERIAL_IN_PIN_IN, FRAME_START_PIN_IN, BIT_CLOCK_PIN_IN};
		n.sync_s = s.sync_m;
		n.bck_p = s.sync_s[SY_BCK];
		if (bck_rise) begin
			n.frm_prev = frm;
			n.shift = word;
			n.pkt_bit = s.pkt_bit + 5'h01;
			if (frm && !s.frm_prev) begin
				// A frame only carries commands once two pulses have qualified.
				n.hi_cnt = 2'h1;
				n.pkt_bit = 5'h01;
				n.shift = {31'h0, din};
				n.slot = SL_NONE;
				n.aud_done = 1'b0;
				n.rd_active = 1'b0;
				n.chain_out = 1'b0;
				n.phase = (s.qual >= QUAL_FRAMES) ? PH_CMD : PH_IDLE;
			end else begin
				if (frm) begin
					n.hi_cnt = (s.hi_cnt == 2'h3) ? s.hi_cnt : s.hi_cnt + 2'h1;
				end else if (s.frm_prev) begin
					// The pulse has ended; a square wave gives a long count and drops the mode.
					if (s.hi_cnt == LEAD_PULSE_BITS && s.ctrl_en) begin
						n.qual = (s.qual == QUAL_FRAMES) ? s.qual : s.qual + 2'h1;
					end else begin
						n.qual = 2'h0;
						n.phase = PH_IDLE;
						n.rd_active = 1'b0;
					end
				end
				// Read is decided once device, chain and direction bits are in.
				if (s.pkt_bit == RD_DECIDE_BIT) begin
					n.rd_active = ((s.phase == PH_CMD && !word[14]) || s.phase == PH_EXT) &&
						tcas_match({word[14:0], 17'h0}, s.dev_id, s.id_valid) &&
						word[RW_BIT - 17];
				end
				if (s.pkt_bit == RD_ADDR_BIT) begin
					n.rd_addr = word[6:0];
				end
				if (s.pkt_bit == RD_LAST_BIT) begin
					n.rd_active = 1'b0;
				end
				// Each bit before the chain input rises adds one to the position.
				if (s.phase == PH_IDASSIGN) begin
					if (chin) begin
						n.dev_id = (s.id_cnt >= MAX_ID - HEAD_ID) ? MAX_ID :
							s.id_cnt + HEAD_ID;
						n.id_valid = 1'b1;
						n.chain_out = 1'b1;
						n.phase = PH_IDLE;
					end else begin
						n.id_cnt = (s.id_cnt == MAX_ID) ? s.id_cnt : s.id_cnt + 5'h01;
					end
				end
				// Skipped device passes chain ownership straight through.
				if (s.phase == PH_AUDIO && s.avail) begin
					n.chain_out = chin;
				end
				if (s.pkt_bit == PKT_LAST_BIT) begin
					unique case (s.phase)
						PH_CMD: begin
							if (word[ID_ASSIGN_BIT]) begin
								n.phase = PH_IDASSIGN;
								n.id_cnt = 5'h00;
								n.id_valid = 1'b0;
							end else begin
								n.phase = word[EXT_BIT] ? PH_EXT : PH_AUDIO;
							end
						end
						PH_EXT: begin
							n.phase = word[EXT_BIT] ? PH_EXT : PH_IDLE;
						end
						PH_AUDIO: begin
							if (s.slot == SL_LEFT) begin
								n.audio_l = word[SAMPLE_LSB +: 24];
								n.slot = SL_RIGHT;
								n.chain_out = 1'b1;
							end else if (s.slot == SL_RIGHT) begin
								n.audio_r = word[SAMPLE_LSB +: 24];
								n.slot = SL_NONE;
								n.aud_done = 1'b1;
								n.chain_out = 1'b0;
							end
						end
						PH_IDLE, PH_IDASSIGN: begin
						end
					endcase
					// A matching write lands when its packet is complete.
					if ((s.phase == PH_CMD && !word[ID_ASSIGN_BIT]) || s.phase == PH_EXT) begin
						if (tcas_match(word, s.dev_id, s.id_valid) && !word[RW_BIT]) begin
							n.wr_count = s.wr_count + 16'h0001;
							if (word[REG_ID_LSB +: 7] != REG_DEVID) begin
								n.wr_en = 1'b1;
								n.wr_addr = word[REG_ID_LSB +: 7];
								n.wr_data = word[DATA_LSB +: 8];
							end
							if (word[REG_ID_LSB +: 7] == REG_AVAIL) begin
								n.avail = word[DATA_LSB + AVAIL_BIT];
							end
						end
					end
					// The next packet is ours when the chain input is high at the last bit of the packet before it.
					if ((s.phase == PH_CMD && !word[ID_ASSIGN_BIT] && !word[EXT_BIT]) ||
						(s.phase == PH_AUDIO && s.slot == SL_NONE)) begin
						if (chin && !s.aud_done && !s.avail) begin
							n.slot = SL_LEFT;
						end
					end
				end
			end
		end
		// The pin is driven on falling edges, one period ahead of the data byte.
		if (bck_fall) begin
			n.rb_oe_n = !s.rd_active;
			n.rb_data = (s.rd_active && s.pkt_bit != RD_ADDR_BIT) ?
				rd_byte[~s.pkt_bit[2:0]] : 1'b0;
		end
		// Bus write channel: address and data are taken in either order.
		if (S_AXI_AWVALID_IN && s.awready) begin
			n.aw_hold = 1'b1;
			n.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && s.wready) begin
			n.w_hold = 1'b1;
			n.w_data = S_AXI_WDATA_IN;
			n.w_lane0 = S_AXI_WSTRB_IN[0];
		end
		if (s.bvalid && S_AXI_BREADY_IN) begin
			n.bvalid = 1'b0;
		end
		if (n.aw_hold && n.w_hold && !n.bvalid) begin
			n.aw_hold = 1'b0;
			n.w_hold = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (n.aw_addr)
				A_CTRL: begin
					if (n.w_lane0) begin
						n.ctrl_en = n.w_data[0];
					end
				end
				A_STATUS, A_AUDIO_L, A_AUDIO_R, A_WR_COUNT: begin
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_hold && !n.bvalid;
		n.wready = !n.w_hold && !n.bvalid;
		// Bus read channel: one outstanding read, answered the next cycle.
		if (s.rvalid && S_AXI_RREADY_IN) begin
			n.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_IN && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			unique case (S_AXI_ARADDR_IN)
				A_CTRL: n.rdata = {31'h0, s.ctrl_en};
				A_STATUS: n.rdata = {15'h0, s.avail, 3'h0, s.dev_id, 6'h0, s.id_valid,
					s.qual >= QUAL_FRAMES};
				A_AUDIO_L: n.rdata = {8'h00, s.audio_l};
				A_AUDIO_R: n.rdata = {8'h00, s.audio_r};
				A_WR_COUNT: n.rdata = {16'h0000, s.wr_count};
				default: begin
					n.rdata = 32'h0000_0000;
					n.rresp = RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;
	end

	// One register stage for the whole state.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			s <= TCAS_RST;
		end else begin
			s <= n;
		end
	end

	assign READBACK_PIN_OUT = s.rb_data;
	assign READBACK_PIN_OE_N_OUT = s.rb_oe_n;
	assign CHAIN_OUT_PIN_OUT = s.chain_out;
	assign S_AXI_AWREADY_OUT = s.awready;
	assign S_AXI_WREADY_OUT = s.wready;
	assign S_AXI_BVALID_OUT = s.bvalid;
	assign S_AXI_BRESP_OUT = s.bresp;
	assign S_AXI_ARREADY_OUT = s.arready;
	assign S_AXI_RVALID_OUT = s.rvalid;
	assign S_AXI_RDATA_OUT = s.rdata;
	assign S_AXI_RRESP_OUT = s.rresp;

	// Checks on the link behaviour.
	sequence fall_s;
		bck_fall;
	endsequence

	sequence early_en_s;
		fall_s and s.rd_active && s.pkt_bit == RD_ADDR_BIT;
	endsequence

	readback_release_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		fall_s and !s.rd_active |=> s.rb_oe_n)
		else $error("Readback pin still driven without a read.");

	early_enable_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		early_en_s |=> !s.rb_oe_n && !s.rb_data)
		else $error("Readback driver not enabled one period early.");

	no_low_byte_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		!s.rb_oe_n |-> s.pkt_bit inside {[5'h0f:5'h18]})
		else $error("Readback driven outside the data byte.");

	mode_entry_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		$rose(s.phase == PH_CMD) |-> $past(s.qual) >= QUAL_FRAMES)
		else $error("Command accepted before two qualifying frames.");

	head_id_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		bck_rise && s.phase == PH_IDASSIGN && s.id_cnt == 5'h00 && chin
		|=> s.dev_id == HEAD_ID && s.id_valid && s.chain_out)
		else $error("Head of chain did not take ID one.");

	id_range_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		s.id_valid |-> s.dev_id != NO_ID && s.dev_id <= MAX_ID)
		else $error("Assigned ID out of range.");

	write_timing_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		s.wr_en |-> $past(bck_rise) && $past(s.pkt_bit) == PKT_LAST_BIT)
		else $error("Register write not at packet end.");

	chain_slot_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		s.phase == PH_AUDIO && !s.avail && s.slot == SL_RIGHT |-> s.chain_out)
		else $error("Chain output low during last own slot.");

	ext_no_audio_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		s.phase == PH_EXT |=> s.phase != PH_AUDIO)
		else $error("Audio slot after extended packet.");

	id_frame_nowrite_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
		s.phase == PH_IDASSIGN |-> !s.wr_en)
		else $error("Write during ID-assign frame.");

endmodule
`default_nettype wire

// >>> tcas_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tcas_pkg::*;
;
	typedef struct packed {logic [31:0] w; logic rd; logic [7:0] b; logic inc;} tcas_row_t;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic frm, serial_bit_clock, sdi, chn, rb, rb_oe_n, co;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, byte_v;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, stray;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] fw [8];
	tcas_row_t rows [10];
	int mismatches = 0, n_tests = 0, cycles = 0, exp_wc = 0;

	// Response readies stay high throughout, so every answer is taken at once.
	tcas_slave dut (
		.CLK_SYS_IN(clk), .RESET_IN(rst), .FRAME_START_PIN_IN(frm), .BIT_CLOCK_PIN_IN(serial_bit_clock),
		.SERIAL_IN_PIN_IN(sdi), .CHAIN_IN_PIN_IN(chn), .READBACK_PIN_OUT(rb),
		.READBACK_PIN_OE_N_OUT(rb_oe_n), .CHAIN_OUT_PIN_OUT(co),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(1'h1), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(1'h1)
	);

	tcas_host_model host (
		.clk_in(clk), .rb_in(rb), .rb_oe_n_in(rb_oe_n), .chain_out_in(co),
		.frame_out(frm), .bck_out(serial_bit_clock), .sdata_out(sdi), .chain_drv_out(chn)
	);

	// System clock at 50 MHz.
	always #10 clk = ~clk;

	// A hung handshake would stall forever, so a cycle ceiling ends the run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task automatic chk_b(input logic g, input logic e, input string m);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: %s got %b want %b", $time, m, g, e);
		end
	endtask

	// Address and data are offered together and each is dropped once taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
	endtask

	task automatic reg_is(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		axi_rd(a, rd_v, rsp);
		chk_w(rd_v & k, e, "register");
	endtask

	task automatic frame(input logic [31:0] a, b, c, input int n, p, ch);
		fw[0] = a;
		fw[1] = b;
		fw[2] = c;
		host.send(fw, n, p, ch);
	endtask

	// Commands for this device always keep the chain-select bit low.
	function automatic logic [31:0] cmd(input logic [4:0] id, input logic rd,
		input logic [6:0] r, input logic [7:0] d);
		return {3'h0, id, rd, r, d, 8'h00};
	endfunction

	initial begin
		rows = '{
			'{cmd(5'h03, 1'h0, 7'h05, 8'ha5), 1'h0, 8'h00, 1'h1},
			'{cmd(5'h03, 1'h1, 7'h05, 8'h00), 1'h1, 8'ha5, 1'h0},
			'{cmd(BROADCAST_ID, 1'h0, 7'h06, 8'h3c), 1'h0, 8'h00, 1'h1},
			'{cmd(BROADCAST_ID, 1'h1, 7'h06, 8'h00), 1'h0, 8'h00, 1'h0},
			'{cmd(5'h03, 1'h1, 7'h06, 8'h00), 1'h1, 8'h3c, 1'h0},
			'{cmd(NO_ID, 1'h0, 7'h05, 8'h00), 1'h0, 8'h00, 1'h0},
			'{cmd(5'h02, 1'h0, 7'h05, 8'h00), 1'h0, 8'h00, 1'h0},
			'{cmd(5'h03, 1'h0, 7'h05, 8'h00) | 32'h20000000, 1'h0, 8'h00, 1'h0},
			'{cmd(5'h03, 1'h1, REG_DEVID, 8'h00), 1'h1, 8'h03, 1'h0},
			'{cmd(5'h03, 1'h1, 7'h05, 8'h00), 1'h1, 8'ha5, 1'h0}
		};
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		// Reset state, an unmapped offset and a write to a read-only offset.
		reg_is(A_STATUS, 32'h3, 32'h0);
		reg_is(A_CTRL, 32'h1, 32'h1);
		axi_rd(8'h20, rd_v, rsp);
		chk_w({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped resp");
		axi_wr(A_STATUS, 32'hffffffff, rsp);
		chk_w({30'h0, rsp}, {30'h0, RESP_OKAY}, "read-only resp");
		$display("test bus done");
		// Two qualifying frames; commands in them are refused.
		frame(cmd(BROADCAST_ID, 1'h0, 7'h07, 8'h11), 0, 0, 1, 2, -1);
		reg_is(A_STATUS, 32'h1, 32'h0);
		frame(cmd(BROADCAST_ID, 1'h0, 7'h07, 8'h11), 0, 0, 1, 2, -1);
		reg_is(A_STATUS, 32'h1, 32'h1);
		reg_is(A_WR_COUNT, 32'hffff, 32'h0);
		// Chain input rises two bits after the command, so this device is third.
		frame(32'h80000000 | cmd(BROADCAST_ID, 1'h0, 7'h07, 8'h11), 0, 0, 2, 2, 34);
		reg_is(A_STATUS, 32'h1f03, 32'h0303);
		reg_is(A_WR_COUNT, 32'hffff, 32'h0);
		chk_b(host.co_cap[33], 1'h0, "chain out early");
		chk_b(host.co_cap[40], 1'h1, "chain out");
		$display("test mode and id done");
		// Command table: readback byte, pin release and accepted-write count.
		for (int k = 0; k < 10; k++) begin
			frame(rows[k].w, 0, 0, 1, 2, -1);
			byte_v = 8'h00;
			stray = 1'h0;
			for (int i = 0; i < 32; i++) begin
				if (i >= 16 && i < 24) byte_v = {byte_v[6:0], host.rb_cap[i]};
				if (host.oe_cap[i] !== 1'h0 && !(rows[k].rd && i >= 15 && i < 24)) stray = 1'h1;
			end
			chk_b(stray, 1'h0, "readback drive");
			if (rows[k].rd) begin
				chk_b(host.oe_cap[15], 1'h1, "early enable");
				chk_w({24'h0, byte_v}, {24'h0, rows[k].b}, "read byte");
			end
			exp_wc += rows[k].inc;
			reg_is(A_WR_COUNT, 32'hffff, exp_wc);
		end
		$display("test commands done");
		// Two owned audio slots; chain output marks the last one.
		frame(cmd(NO_ID, 1'h0, 7'h00, 8'h00), 32'h12345600, 32'h89abcd00, 3, 2, -1);
		reg_is(A_AUDIO_L, 32'hffffff, 32'h123456);
		reg_is(A_AUDIO_R, 32'hffffff, 32'h89abcd);
		chk_b(host.co_cap[48], 1'h0, "chain out left");
		chk_b(host.co_cap[80], 1'h1, "chain out right");
		// Availability bit set: slots are no longer taken.
		frame(cmd(5'h03, 1'h0, REG_AVAIL, 8'h10), 0, 0, 1, 2, -1);
		exp_wc++;
		reg_is(A_STATUS, 32'h10000, 32'h10000);
		frame(cmd(NO_ID, 1'h0, 7'h00, 8'h00), 32'h11111100, 32'h22222200, 3, 2, -1);
		reg_is(A_AUDIO_L, 32'hffffff, 32'h123456);
		$display("test audio done");
		// Extended frame: both packets write, the reserved top bit is not an ID flag.
		frame(cmd(5'h03, 1'h0, REG_AVAIL, 8'h00) | 32'h40000000,
			32'h80000000 | cmd(5'h03, 1'h0, 7'h05, 8'h5a), 32'h33333300, 3, 2, -1);
		exp_wc += 2;
		reg_is(A_WR_COUNT, 32'hffff, exp_wc);
		reg_is(A_AUDIO_L, 32'hffffff, 32'h123456);
		reg_is(A_STATUS, 32'h11f03, 32'h00303);
		// A three-bit lead pulse drops the mode and the command with it.
		frame(cmd(5'h03, 1'h0, 7'h05, 8'h77), 0, 0, 1, 3, -1);
		reg_is(A_STATUS, 32'h1, 32'h0);
		reg_is(A_WR_COUNT, 32'hffff, exp_wc);
		$display("test extended and drop done");
		// Mid-run reset clears the ID and the mode; detection can be switched off.
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		chk_b(rb_oe_n, 1'h1, "reset release");
		reg_is(A_STATUS, 32'h11f03, 32'h0);
		reg_is(A_WR_COUNT, 32'hffff, 32'h0);
		axi_wr(8'h20, 32'h0, rsp);
		chk_w({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
		axi_wr(A_CTRL, 32'h0, rsp);
		reg_is(A_CTRL, 32'h1, 32'h0);
		repeat (2) frame(0, 0, 0, 1, 2, -1);
		reg_is(A_STATUS, 32'h1, 32'h0);
		axi_wr(A_CTRL, 32'h1, rsp);
		// An even-duty frame pin never qualifies, so one good frame after it is not enough.
		frame(0, 0, 0, 1, 16, -1);
		frame(0, 0, 0, 1, 2, -1);
		reg_is(A_STATUS, 32'h1, 32'h0);
		frame(0, 0, 0, 1, 2, -1);
		reg_is(A_STATUS, 32'h1, 32'h1);
		// Chain input tied high makes this device the head of the chain.
		frame(32'h80000000, 0, 0, 2, 2, -1);
		reg_is(A_STATUS, 32'h1f03, 32'h0103);
		chk_b(host.co_cap[31], 1'h0, "head chain out early");
		chk_b(host.co_cap[32], 1'h1, "head chain out");
		$display("test reset and head done");
		end_sim();
	end
endmodule
`default_nettype wire
